// [verilog/bsc_pkg.sv]
// constants shared by the supply switch-over controller files
package bsc_pkg;

  // register addresses on the documented register port
  localparam logic [7:0] ADDR_CTL   = 8'h26;
  localparam logic [7:0] ADDR_FLAGS = 8'h2b;

  // switch-over control register field positions
  localparam int CTL_THRESH_BIT  = 0;
  localparam int CTL_POLICY_LO   = 1;
  localparam int CTL_POLICY_HI   = 2;
  localparam int CTL_REFRESH_BIT = 3;
  localparam int CTL_DISABLE_BIT = 4;

  // flags register: position of the switch-over flag
  localparam int FLAG_SWITCH_BIT = 5;

  // reset values of the control fields
  localparam logic       THRESH_RST  = 1'b0;
  localparam logic [1:0] POLICY_RST  = 2'h0;
  localparam logic       REFRESH_RST = 1'b0;
  localparam logic       DISABLE_RST = 1'b0;

  // switching policies
  typedef enum logic [1:0] {
    BSC_POL_THRESH = 2'h0,  // battery when below threshold
    BSC_POL_BATT   = 2'h1,  // battery when below battery voltage
    BSC_POL_HIGHER = 2'h2,  // battery when below the higher of both
    BSC_POL_LOWER  = 2'h3   // battery when below the lower of both
  } bsc_policy_t;

  // timestamp pin modes
  localparam logic [1:0] TS_OFF      = 2'h0;
  localparam logic [1:0] TS_OUT_IRQ  = 2'h1;
  localparam logic [1:0] TS_OUT_CLK  = 2'h2;
  localparam logic [1:0] TS_IN       = 2'h3;

  // slow release clock for interrupt pulses
  localparam int CLOCK_HZ     = 100_000_000;
  localparam int SLOW_TICK_HZ = 128;
  localparam int SLOW_DIV     = CLOCK_HZ / SLOW_TICK_HZ;

endpackage : bsc_pkg

// [verilog/bsc_slow_tick.sv]
// divider that makes the one-cycle slow tick for pulse release
`timescale 1ns/100ps
module bsc_slow_tick #(
  parameter int DIV = bsc_pkg::SLOW_DIV  // clock cycles per tick
) (
  input  wire logic clock,  // system clock
  input  wire logic srst,   // synchronous reset
  output logic      tick    // one-cycle pulse every DIV cycles
);

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } bsc_tick_state_t;

  bsc_tick_state_t state;
  bsc_tick_state_t next_state;

  // free-running count; tick on wrap
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (state.count == 32'(DIV - 1)) begin
      next_state.count = 32'h0;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule : bsc_slow_tick

// [verilog/bsc_irq_pulse.sv]
// interrupt pulse held until the second slow tick after its start
`timescale 1ns/100ps
module bsc_irq_pulse (
  input  wire logic clock,   // system clock
  input  wire logic srst,    // synchronous reset
  input  wire logic tick,    // slow release tick
  input  wire logic fire,    // start or restart the pulse
  input  wire logic abort,   // flag cleared: cut the pulse short
  output logic      active   // pulse level, active high
);

  typedef struct packed {
    logic active;
    logic seen_tick;
  } bsc_pulse_state_t;

  bsc_pulse_state_t state;
  bsc_pulse_state_t next_state;

  // tick is unrelated to the event, so length is one to two periods
  always_comb begin
    next_state = state;
    if (fire) begin
      next_state.active    = 1'b1;
      next_state.seen_tick = 1'b0;
    end else if (abort) begin
      next_state.active    = 1'b0;
      next_state.seen_tick = 1'b0;
    end else if (state.active && tick) begin
      if (state.seen_tick) begin
        next_state.active    = 1'b0;
        next_state.seen_tick = 1'b0;
      end else begin
        next_state.seen_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = state.active;

endmodule : bsc_irq_pulse

// [verilog/bsc_switchover_ctrl.sv]
// supply switch-over controller: source select, flag, irq and pin gating
//
// How it works
// - source changes automatically from comparator inputs, policy and disable bit only.
// - policy field bits 2:1, reset 00; 00 threshold, 01 battery compare.
// - policy 10: battery when supply below the higher of both levels.
// - policy 11: battery when supply below the lower of both levels.
// - each main-to-battery transition sets the switch-over flag.
// - flag readable only on main supply; register port dead on battery.
// - enabled battery transition gives a pulse or a static low level.
// - enabled return to main supply can give an interrupt pulse.
// - on battery host bus pins ignored and clock output pin floats.
// - on battery timestamp pin output functions off, pin floats.
// - on battery timestamp digital input is ignored.
// - timestamp switch detection works on main and on battery.
// - on battery primary irq pin keeps irq and indication, no clock.
// - control bit 4 set disables switch-over; reset value 0.
// - control bit 0 picks the threshold: 0 lower, 1 higher.
// - the switch-over flag stays set until software clears it.
// - enabled pulse on every switch-over, flag cleared or not.
// - pulse ends on the slow clock or on a flag clear, lasting at most two of its periods.
`timescale 1ns/100ps
module bsc_switchover_ctrl #(
  parameter int SLOW_DIV = bsc_pkg::SLOW_DIV  // cycles per 128 Hz tick
) (
  input  wire logic       clock,               // always-on clock
  input  wire logic       srst,                // power-on reset, sync
  // comparator results, already synchronous
  input  wire logic       above_threshold,     // supply above threshold
  input  wire logic       above_battery,       // supply above battery
  // register port of the host bus
  input  wire logic [7:0] reg_addr,            // register address
  input  wire logic [7:0] reg_wdata,           // write data
  input  wire logic       reg_wr,              // write strobe
  input  wire logic       reg_rd,              // read strobe
  output logic      [7:0] reg_rdata,           // read data, next cycle
  output logic            reg_rvalid,          // read data valid pulse
  // interrupt configuration from the interrupt control block
  input  wire logic       irq_en_to_battery,   // irq on switch to battery
  input  wire logic       irq_en_to_main,      // irq on switch to main
  input  wire logic       irq_level_mode,      // 1 static level, 0 pulse
  input  wire logic       irq_pin_batt_ind,    // pin shows battery mode
  input  wire logic       irq_pin_clk_mode,    // pin shows clock output
  input  wire logic       other_irq_n,         // other irq sources, low
  input  wire logic       secondary_irq_n,     // secondary irq data, low
  // clock output
  input  wire logic       clk_src,             // selected output clock
  input  wire logic       clkout_enable,       // clock pin enabled
  // timestamp pin
  input  wire logic [1:0] ts_mode,             // pin io mode
  input  wire logic       timestamp_pin_i,     // pin level in
  input  wire logic       ts_switch_i,         // switch detector level
  // status and pins
  output logic            on_battery,          // running from battery
  output logic            switchover_flag,     // sticky flag
  output logic            threshold_select,    // to comparator
  output logic            switchover_refresh_rate, // to comparator
  output logic            host_bus_enable,     // host pins are listened to
  output logic            primary_irq_pin_o,   // primary irq pin out
  output logic            primary_irq_pin_oe,  // primary irq pin drive
  output logic            clkout_pin_o,        // clock pin out
  output logic            clkout_pin_oe,       // clock pin drive
  output logic            timestamp_pin_o,     // timestamp pin out
  output logic            timestamp_pin_oe,    // timestamp pin drive
  output logic            ts_input_level,      // gated digital input
  output logic            ts_switch_level      // switch detector level
);

  typedef struct packed {
    logic              thresh;
    bsc_pkg::bsc_policy_t policy;
    logic              refresh;
    logic              disable_sw;
    logic              flag;
    logic              batt;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              irq_o;
    logic              irq_oe;
    logic              clk_o;
    logic              clk_oe;
    logic              ts_o;
    logic              ts_oe;
    logic              ts_in;
    logic              ts_sw;
  } bsc_state_t;

  bsc_state_t state;
  bsc_state_t next_state;

  logic slow_tick;
  logic pulse_active;
  logic want_batt;
  logic to_batt;
  logic to_main;
  logic fire;
  logic flag_clear;
  logic bus_live;
  logic irq_low;

  // slow tick releases interrupt pulses
  bsc_slow_tick #(
    .DIV (SLOW_DIV)
  ) u_tick (
    .clock (clock),
    .srst  (srst),
    .tick  (slow_tick)
  );

  // pulse generator, cut short when the flag is cleared
  bsc_irq_pulse u_pulse (
    .clock  (clock),
    .srst   (srst),
    .tick   (slow_tick),
    .fire   (fire),
    .abort  (flag_clear),
    .active (pulse_active)
  );

  // policy decode of the two comparator results
  always_comb begin
    unique case (state.policy)
      bsc_pkg::BSC_POL_THRESH: want_batt = !above_threshold;
      bsc_pkg::BSC_POL_BATT:   want_batt = !above_battery;
      // below the higher of the two means below either one
      bsc_pkg::BSC_POL_HIGHER: begin
        want_batt = !(above_threshold && above_battery);
      end
      // below the lower of the two means below both
      bsc_pkg::BSC_POL_LOWER: begin
        want_batt = !(above_threshold || above_battery);
      end
    endcase
    if (state.disable_sw) begin
      want_batt = 1'b0;
    end
  end

  // transition events; software reaches the source through policy and disable bits, and through the threshold bit via the comparator
  assign to_batt = want_batt && !state.batt;
  assign to_main = !want_batt && state.batt;
  // pulse on either direction, whatever the flag holds
  assign fire = (to_batt && irq_en_to_battery) ||
                (to_main && irq_en_to_main);

  // host port is dead while the main domain is down
  assign bus_live   = !state.batt;
  assign flag_clear = bus_live && reg_wr && (reg_addr == bsc_pkg::ADDR_FLAGS)
                      && !reg_wdata[bsc_pkg::FLAG_SWITCH_BIT];

  // active-low interrupt demand from this block and the others
  always_comb begin
    if (irq_level_mode) begin
      irq_low = state.flag && irq_en_to_battery;
    end else begin
      irq_low = pulse_active;
    end
    irq_low = irq_low || !other_irq_n;
  end

  // next state: registers, flag, source and pins
  always_comb begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    next_state.batt   = want_batt;

    // register writes only while on the main supply
    if (bus_live && reg_wr && reg_addr == bsc_pkg::ADDR_CTL) begin
      next_state.thresh  = reg_wdata[bsc_pkg::CTL_THRESH_BIT];
      next_state.policy  = bsc_pkg::bsc_policy_t'(
        reg_wdata[bsc_pkg::CTL_POLICY_HI:bsc_pkg::CTL_POLICY_LO]);
      // refresh bit is stored as written; software keeps it at 0
      next_state.refresh = reg_wdata[bsc_pkg::CTL_REFRESH_BIT];
      next_state.disable_sw = reg_wdata[bsc_pkg::CTL_DISABLE_BIT];
    end

    // sticky flag: write 0 clears, a new switch wins over the clear
    if (flag_clear) begin
      next_state.flag = 1'b0;
    end
    if (to_batt) begin
      next_state.flag = 1'b1;
    end

    // reads answer one cycle later; unmapped reads give zero
    if (bus_live && reg_rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = 8'h00;
      if (reg_addr == bsc_pkg::ADDR_CTL) begin
        next_state.rdata[bsc_pkg::CTL_THRESH_BIT]  = state.thresh;
        next_state.rdata[bsc_pkg::CTL_POLICY_HI:bsc_pkg::CTL_POLICY_LO] =
          state.policy;
        next_state.rdata[bsc_pkg::CTL_REFRESH_BIT] = state.refresh;
        next_state.rdata[bsc_pkg::CTL_DISABLE_BIT] = state.disable_sw;
      end else if (reg_addr == bsc_pkg::ADDR_FLAGS) begin
        next_state.rdata[bsc_pkg::FLAG_SWITCH_BIT] = state.flag;
      end
    end

    // primary irq pin: indicator, then clock (main only), then irq
    if (irq_pin_batt_ind) begin
      next_state.irq_o  = 1'b0;
      next_state.irq_oe = want_batt;
    end else if (irq_pin_clk_mode && !want_batt) begin
      next_state.irq_o  = clk_src;
      next_state.irq_oe = 1'b1;
    end else begin
      // open-drain style: only ever pulls low
      next_state.irq_o  = 1'b0;
      next_state.irq_oe = irq_low;
    end

    // clock output floats on battery
    next_state.clk_o  = clk_src;
    next_state.clk_oe = clkout_enable && !want_batt;

    // timestamp pin output functions need the main domain
    next_state.ts_o  = 1'b0;
    next_state.ts_oe = 1'b0;
    if (!want_batt && ts_mode == bsc_pkg::TS_OUT_IRQ) begin
      next_state.ts_o  = secondary_irq_n;
      next_state.ts_oe = 1'b1;
    end else if (!want_batt && ts_mode == bsc_pkg::TS_OUT_CLK) begin
      next_state.ts_o  = clk_src;
      next_state.ts_oe = 1'b1;
    end

    // digital input ignored on battery, so a floating pin is harmless
    next_state.ts_in = (ts_mode == bsc_pkg::TS_IN) && !want_batt &&
                       timestamp_pin_i;
    // switch detector sits in the always-on domain
    next_state.ts_sw = ts_switch_i;
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      next_state_reset : begin
        state            <= '0;
        state.thresh     <= bsc_pkg::THRESH_RST;
        state.policy     <= bsc_pkg::bsc_policy_t'(bsc_pkg::POLICY_RST);
        state.refresh    <= bsc_pkg::REFRESH_RST;
        state.disable_sw <= bsc_pkg::DISABLE_RST;
      end
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  assign reg_rdata               = state.rdata;
  assign reg_rvalid              = state.rvalid;
  assign on_battery              = state.batt;
  assign switchover_flag         = state.flag;
  assign threshold_select        = state.thresh;
  assign switchover_refresh_rate = state.refresh;
  assign host_bus_enable         = !state.batt;
  assign primary_irq_pin_o       = state.irq_o;
  assign primary_irq_pin_oe      = state.irq_oe;
  assign clkout_pin_o            = state.clk_o;
  assign clkout_pin_oe           = state.clk_oe;
  assign timestamp_pin_o         = state.ts_o;
  assign timestamp_pin_oe        = state.ts_oe;
  assign ts_input_level          = state.ts_in;
  assign ts_switch_level         = state.ts_sw;

endmodule : bsc_switchover_ctrl

// [tb/bsc_switchover_chk.sv]
// port assertions for the supply switch-over controller
`timescale 1ns/100ps
module bsc_switchover_chk #(
  parameter int SLOW_DIV = 8  // cycles per slow tick
) (
  input wire logic       clock,              // clock
  input wire logic       srst,               // sync reset
  input wire logic       above_threshold,    // comparator
  input wire logic       above_battery,      // comparator
  input wire logic [7:0] reg_addr,           // address
  input wire logic [7:0] reg_wdata,          // write data
  input wire logic       reg_wr,             // write strobe
  input wire logic       reg_rd,             // read strobe
  input wire logic [7:0] reg_rdata,          // read data
  input wire logic       reg_rvalid,         // read valid
  input wire logic       irq_en_to_battery,  // irq enable
  input wire logic       irq_en_to_main,     // irq enable
  input wire logic       irq_level_mode,     // level mode
  input wire logic       irq_pin_batt_ind,   // indicator mode
  input wire logic       irq_pin_clk_mode,   // clock mode
  input wire logic       ts_switch_i,        // switch level
  input wire logic       on_battery,         // source
  input wire logic       switchover_flag,    // sticky flag
  input wire logic       threshold_select,   // ctl bit 0
  input wire logic       host_bus_enable,    // host pins live
  input wire logic       primary_irq_pin_oe, // irq drive
  input wire logic       clkout_pin_oe,      // clock drive
  input wire logic       timestamp_pin_oe,   // ts drive
  input wire logic       ts_switch_level     // switch out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [1:0] pol;
  logic       dis;
  logic       thr;
  logic       exp_batt;
  int         pcnt;
  wire ctl_wr = reg_wr && !on_battery && reg_addr == bsc_pkg::ADDR_CTL;
  wire pulse_on = primary_irq_pin_oe && !irq_level_mode && !irq_pin_batt_ind;
  // shadow of the control fields; writes on battery are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      pol      <= 2'h0;
      dis      <= 1'b0;
      thr      <= 1'b0;
      exp_batt <= 1'b0;
    end else begin
      if (ctl_wr) {dis, pol, thr} <= {reg_wdata[4], reg_wdata[2:0]};
      case (pol)
        2'h0:    exp_batt <= !dis && !above_threshold;
        2'h1:    exp_batt <= !dis && !above_battery;
        2'h2:    exp_batt <= !dis && !(above_threshold && above_battery);
        default: exp_batt <= !dis && !(above_threshold || above_battery);
      endcase
    end
  end
  // pulse length counter, restarted at each switch-over
  always_ff @(posedge clock) begin
    if (srst || !pulse_on || on_battery != $past(on_battery)) pcnt <= 0;
    else pcnt <= pcnt + 1;
  end
  sequence pulse_cfg;
    !irq_level_mode && !irq_pin_batt_ind && !irq_pin_clk_mode;
  endsequence
  source_sel_a: assert property (on_battery == exp_batt)
    else $error("power source differs from policy");
  thresh_bit_a: assert property (threshold_select == thr)
    else $error("threshold select differs from control bit");
  pins_float_a: assert property (on_battery |-> !host_bus_enable && !clkout_pin_oe)
    else $error("host bus or clock pin live on battery");
  ts_float_a: assert property (on_battery |-> !timestamp_pin_oe)
    else $error("timestamp pin driven on battery");
  flag_set_a: assert property ($rose(on_battery) |-> switchover_flag)
    else $error("flag not set on switch to battery");
  flag_sticky_a: assert property ($fell(switchover_flag) |-> $past(reg_wr && reg_addr == bsc_pkg::ADDR_FLAGS && !reg_wdata[5]))
    else $error("flag cleared without a write");
  read_gate_a: assert property (reg_rd |=> reg_rvalid == !$past(on_battery))
    else $error("read answer wrong for supply state");
  flag_read_a: assert property (reg_rd && !on_battery && reg_addr == bsc_pkg::ADDR_FLAGS |=> reg_rdata == {2'h0, $past(switchover_flag), 5'h00})
    else $error("flags read wrong");
  batt_pulse_a: assert property ($rose(on_battery) ##0 pulse_cfg ##0 irq_en_to_battery |=> primary_irq_pin_oe)
    else $error("no pulse on switch to battery");
  main_pulse_a: assert property ($fell(on_battery) ##0 pulse_cfg ##0 irq_en_to_main |=> primary_irq_pin_oe)
    else $error("no pulse on return to main");
  pulse_len_a: assert property (pcnt <= 2 * SLOW_DIV + 2)
    else $error("pulse outlasts two slow ticks");
  switch_det_a: assert property (!$past(srst) |-> ts_switch_level == $past(ts_switch_i))
    else $error("switch detector level lost");
endmodule : bsc_switchover_chk
bind bsc_switchover_ctrl bsc_switchover_chk #(.SLOW_DIV(SLOW_DIV)) i_chk (.*);

// [tb/bsc_supply_model.sv]
// behavioural supply comparators in front of the switch-over controller
`timescale 1ns/100ps
module bsc_supply_model (
  input  wire logic clock,            // always-on clock
  input  wire logic threshold_select, // high picks the upper threshold
  input  int        vdd,              // main supply, tenths of a volt
  input  int        vbat,             // battery, tenths of a volt
  output logic      above_threshold,  // supply above threshold
  output logic      above_battery     // supply above battery
);
  int vth;
  // threshold in tenths of a volt: 1.5 V low, 2.8 V high
  assign vth = threshold_select ? 28 : 15;
  // registered results stand in for the synchroniser stage
  always @(posedge clock) begin
    above_threshold <= vdd > vth;
    above_battery   <= vdd > vbat;
  end
endmodule : bsc_supply_model

// [tb/tb_bsc_switchover_ctrl.sv]
// self-checking bench for the supply switch-over controller
`timescale 1ns/100ps
module tb_bsc_switchover_ctrl;
  localparam int DIV = 8;  // short slow tick keeps pulses brief
  logic clock, srst, above_threshold, above_battery, reg_wr, reg_rd;
  logic reg_rvalid, irq_en_to_battery, irq_en_to_main, irq_level_mode;
  logic irq_pin_batt_ind, irq_pin_clk_mode, other_irq_n, secondary_irq_n;
  logic clk_src, clkout_enable, timestamp_pin_i, ts_switch_i, on_battery;
  logic switchover_flag, threshold_select, switchover_refresh_rate;
  logic host_bus_enable, primary_irq_pin_o, primary_irq_pin_oe;
  logic clkout_pin_o, clkout_pin_oe, timestamp_pin_o, timestamp_pin_oe;
  logic ts_input_level, ts_switch_level, a, b, e;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] ts_mode;
  int         vdd, vbat, bad_count, compares, cycles, n;
  int         lv[3] = '{40, 20, 10};
  bsc_switchover_ctrl #(.SLOW_DIV(DIV)) i_dut (.*);
  bsc_supply_model i_supply (.*);
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic chk1(input string what, input logic seen, exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask : chk1
  // one-cycle strobes, entered and left just after an edge
  task automatic wr(input logic [7:0] ad, d);
    @(posedge clock); #1;
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock); #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic v, input logic [7:0] d);
    @(posedge clock); #1;
    reg_addr = ad;
    reg_rd = 1'b1;
    @(posedge clock); #1;
    reg_rd = 1'b0;
    chk1("rvalid", reg_rvalid, v);
    if (v) check("rdata", reg_rdata, d);
  endtask : rd
  // set the main supply, then let cnt edges pass
  task automatic go(input int v, input int cnt);
    vdd = v;
    repeat (cnt) @(posedge clock);
    #1;
  endtask : go
  task automatic wait_pulse();
    n = 0;
    while (primary_irq_pin_oe === 1'b1 && n < 40) begin
      @(posedge clock); #1;
      n++;
    end
    chk1("pulse len", n <= 2 * DIV, 1'b1);
  endtask : wait_pulse
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {srst, reg_wr, reg_rd, irq_en_to_battery, irq_en_to_main} = 5'h10;
    {irq_level_mode, irq_pin_batt_ind, irq_pin_clk_mode, clk_src} = 4'h0;
    {timestamp_pin_i, ts_switch_i} = 2'h0;
    {other_irq_n, secondary_irq_n, clkout_enable} = 3'h7;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ts_mode = bsc_pkg::TS_OUT_IRQ;
    {vdd, vbat, bad_count, compares, cycles} = {32'd40, 32'd30, 96'd0};
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    rd(bsc_pkg::ADDR_CTL, 1'b1, 8'h00);
    rd(bsc_pkg::ADDR_FLAGS, 1'b1, 8'h00);
    chk1("refresh", switchover_refresh_rate, 1'b0);
    wr(bsc_pkg::ADDR_CTL, 8'he1);
    rd(bsc_pkg::ADDR_CTL, 1'b1, 8'h01);
    chk1("thresh", threshold_select, 1'b1);
    rd(8'h30, 1'b1, 8'h00);
    go(20, 4);
    chk1("batt high th", on_battery, 1'b1);
    go(40, 4);
    // every policy against above, between and below both levels
    for (int p = 0; p < 4; p++) begin
      wr(bsc_pkg::ADDR_CTL, 8'(p << 1));
      foreach (lv[i]) begin
        go(lv[i], 4);
        a = lv[i] > 15;
        b = lv[i] > 30;
        e = (p == 0) ? !a : (p == 1) ? !b : (p == 2) ? !(a && b) : !(a || b);
        chk1("batt", on_battery, e);
      end
      go(40, 4);
    end
    wr(bsc_pkg::ADDR_FLAGS, 8'h00);
    irq_en_to_battery = 1'b1;
    irq_en_to_main = 1'b1;
    wr(bsc_pkg::ADDR_CTL, 8'h00);
    chk1("clk oe", clkout_pin_oe, 1'b1);
    chk1("ts oe", timestamp_pin_oe, 1'b1);
    chk1("ts o", timestamp_pin_o, secondary_irq_n);
    chk1("clk o", clkout_pin_o, clk_src);
    chk1("irq o", primary_irq_pin_o, 1'b0);
    ts_switch_i = 1'b1;
    go(10, 3);
    chk1("flag", switchover_flag, 1'b1);
    chk1("bus", host_bus_enable, 1'b0);
    chk1("clk oe", clkout_pin_oe, 1'b0);
    chk1("ts oe", timestamp_pin_oe, 1'b0);
    chk1("irq oe", primary_irq_pin_oe, 1'b1);
    chk1("switch", ts_switch_level, 1'b1);
    rd(bsc_pkg::ADDR_FLAGS, 1'b0, 8'h00);
    wait_pulse();
    go(40, 3);
    chk1("irq oe", primary_irq_pin_oe, 1'b1);
    wait_pulse();
    rd(bsc_pkg::ADDR_FLAGS, 1'b1, 8'h20);
    wr(bsc_pkg::ADDR_FLAGS, 8'h20);
    rd(bsc_pkg::ADDR_FLAGS, 1'b1, 8'h20);
    wr(bsc_pkg::ADDR_FLAGS, 8'h00);
    rd(bsc_pkg::ADDR_FLAGS, 1'b1, 8'h00);
    // level mode holds the pin for as long as the flag stays set
    irq_level_mode = 1'b1;
    go(10, 3 * DIV);
    chk1("level", primary_irq_pin_oe, 1'b1);
    go(40, 4);
    chk1("level", primary_irq_pin_oe, 1'b1);
    wr(bsc_pkg::ADDR_FLAGS, 8'h00);
    go(40, 2);
    chk1("level", primary_irq_pin_oe, 1'b0);
    irq_level_mode = 1'b0;
    wr(bsc_pkg::ADDR_CTL, 8'h10);
    ts_mode = bsc_pkg::TS_IN;
    timestamp_pin_i = 1'b1;
    go(10, 4);
    chk1("disabled", on_battery, 1'b0);
    chk1("ts in", ts_input_level, 1'b1);
    rd(bsc_pkg::ADDR_CTL, 1'b1, 8'h10);
    close_out();
  end
endmodule : tb_bsc_switchover_ctrl
